// ---- design/wakeup_timers.sv ----
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "wakeup_timers_regs.svh"
module wakeup_timers
  import wakeup_timers_pkg::*;
#(
  parameter int unsigned METHODS = 2
)(
  input  wire logic                           clk_in,         // 125 MHz clock
  input  wire logic                           rst_b_in,       // async reset, active low
  input  wire wakeup_timers_pkg::bus_req_type bus_in,         // register bus request
  output logic [7:0]                          rdata_out,      // read data, cycle after read
  input  wire wakeup_timers_pkg::link_ev_type link_in,        // front-end events
  input  wire logic [7:0]                     meas_value_in,  // measurement result
  input  wire logic                           meas_done_in,   // measurement result valid
  output logic                                meas_req_out,   // measurement request pulse
  output logic                                meas_phase_out, // method of request
  output logic                                rx_on_out,      // receiver enable
  output logic                                squelch_out,    // squelch active
  output logic                                rc_osc_en_out,  // RC oscillator enable
  output logic [3:0]                          events_out      // sticky event flags
);
  import wakeup_timers_pkg::*;

  localparam int unsigned SQ_CYCLES = (`SQUELCH_DELAY_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;

  // refuse method counts that the register map cannot serve
  if (METHODS != 2)
    $error("wakeup_timers serves exactly two measurement methods");

  state_type s;
  state_type next_s;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // wake interval code to RC ticks
  function automatic logic [15:0] wake_ticks(input logic [2:0] code);
    logic [9:0] ms;
    ms = 10'd10;
    unique case (code)
      3'h0: ms = 10'd10;
      3'h1: ms = 10'd20;
      3'h2: ms = 10'd50;
      3'h3: ms = 10'd100;
      3'h4: ms = 10'd200;
      3'h5: ms = 10'd400;
      3'h6: ms = 10'd600;
      3'h7: ms = 10'd800;
    endcase
    wake_ticks = 16'(ms * `RC_TICKS_PER_MS);
  endfunction

  // end of a prescaler step, mask is step length minus one
  function automatic logic step_end(input timer_type t, input logic tick, input logic [11:0] mask);
    step_end = t.run & tick & ((t.pre & mask) == mask);
  endfunction

  // advance a timer, returns expiry in bit 0 of the flag
  function automatic timer_type advance(input timer_type t, input logic tick, input logic [11:0] mask,
                                        output logic expire);
    timer_type r;
    r = t;
    expire = 1'b0;
    if (t.run && tick)
    begin
      r.pre = t.pre + 12'h001;
      if (step_end(t, tick, mask))
      begin
        if (t.cnt <= 16'h0001)
        begin
          r.run = 1'b0;
          r.cnt = 16'h0000;
          expire = 1'b1;
        end
        else
          r.cnt = t.cnt - 16'h0001;
      end
    end
    advance = r;
  endfunction

  function automatic timer_type load(input logic [15:0] count);
    timer_type r;
    r.run = 1'b1;
    r.cnt = count;
    r.pre = 12'h000;
    load = r;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    logic       wr_cmd;
    logic       wake_mode;
    logic       target;
    logic       mrt_exp;
    logic       nrt_exp;
    logic       gpt_exp;
    logic       wut_exp;
    logic       mrt_tick;
    logic [11:0] mrt_mask;
    logic       uncond;
    logic       m;
    logic [9:0] ref10;
    logic [7:0] ref8;
    logic [7:0] diff;
    logic       hit;
    logic signed [11:0] delta;
    logic [3:0] ev_set;
    wr_cmd    = 1'b0;
    wake_mode = 1'b0;
    target    = 1'b0;
    mrt_exp   = 1'b0;
    nrt_exp   = 1'b0;
    gpt_exp   = 1'b0;
    wut_exp   = 1'b0;
    mrt_tick  = 1'b0;
    mrt_mask  = 12'h000;
    uncond    = 1'b0;
    m         = 1'b0;
    ref10     = 10'h000;
    ref8      = 8'h00;
    diff      = 8'h00;
    hit       = 1'b0;
    delta     = 12'sh000;
    ev_set    = 4'h0;
    next_s    = s;
    next_s.meas_req = 1'b0;

    wake_mode = (s.op_control == (8'h01 << `BIT_OP_WAKEUP));
    target    = s.op_control[`BIT_OP_TARGET];
    uncond    = s.timer_control[`BIT_TC_NRT_UNCOND];

    // register read, data valid the cycle after
    next_s.rdata = 8'h00;
    if (bus_in.rd)
    begin
      if (bus_in.addr >= `OFS_AMP_CONFIG && bus_in.addr < `OFS_AMP_CONFIG + 8'h08)
      begin
        m = (bus_in.addr - `OFS_AMP_CONFIG) >= 8'h04;
        unique case (2'((bus_in.addr - `OFS_AMP_CONFIG) & 8'h03))
          2'h0: next_s.rdata = s.method[m].cfg;
          2'h1: next_s.rdata = s.method[m].host_ref;
          2'h2: next_s.rdata = s.method[m].avg_ref[9:2];
          2'h3: next_s.rdata = s.method[m].last;
        endcase
      end
      else
        unique case (bus_in.addr)
          `OFS_OP_CONTROL:    next_s.rdata = s.op_control;
          `OFS_MRT_COUNT:     next_s.rdata = s.mrt_count;
          `OFS_SQUELCH_COUNT: next_s.rdata = s.squelch_count;
          `OFS_NRT_HIGH:      next_s.rdata = s.nrt_count[15:8];
          `OFS_NRT_LOW:       next_s.rdata = s.nrt_count[7:0];
          `OFS_TIMER_CONTROL: next_s.rdata = s.timer_control;
          `OFS_GPT_HIGH:      next_s.rdata = s.gpt_count[15:8];
          `OFS_GPT_LOW:       next_s.rdata = s.gpt_count[7:0];
          `OFS_EVENT_STATUS:  next_s.rdata = {4'h0, s.events};
          `OFS_TIMER_STATUS:  next_s.rdata = {4'h0, s.wut.run, s.gpt.run, s.nrt.run, s.mrt.run};
          `OFS_WAKEUP_CTRL:   next_s.rdata = s.wakeup_ctrl;
          default:            next_s.rdata = 8'h00;
        endcase
    end

    // register writes
    if (bus_in.wr)
    begin
      if (bus_in.addr >= `OFS_AMP_CONFIG && bus_in.addr < `OFS_AMP_CONFIG + 8'h08)
      begin
        m = (bus_in.addr - `OFS_AMP_CONFIG) >= 8'h04;
        if (2'((bus_in.addr - `OFS_AMP_CONFIG) & 8'h03) == 2'h0)
          next_s.method[m].cfg = bus_in.wdata;
        if (2'((bus_in.addr - `OFS_AMP_CONFIG) & 8'h03) == 2'h1)
          next_s.method[m].host_ref = bus_in.wdata;
      end
      else
        unique case (bus_in.addr)
          `OFS_OP_CONTROL:    next_s.op_control = bus_in.wdata;
          `OFS_MRT_COUNT:     next_s.mrt_count = bus_in.wdata;
          `OFS_SQUELCH_COUNT: next_s.squelch_count = bus_in.wdata;
          `OFS_NRT_HIGH:      next_s.nrt_count[15:8] = bus_in.wdata;
          `OFS_NRT_LOW:       next_s.nrt_count[7:0] = bus_in.wdata;
          `OFS_TIMER_CONTROL: next_s.timer_control = bus_in.wdata;
          `OFS_GPT_HIGH:      next_s.gpt_count[15:8] = bus_in.wdata;
          `OFS_GPT_LOW:       next_s.gpt_count[7:0] = bus_in.wdata;
          `OFS_WAKEUP_CTRL:   next_s.wakeup_ctrl = bus_in.wdata;
          `OFS_COMMAND:       wr_cmd = 1'b1;
          default:            ;
        endcase
    end

    // ****************************************************************
    // timers advance
    // ****************************************************************
    // mask timer tick: RC before crystal is stable in low-power target with the MRT step bit set
    if (s.op_control[`BIT_OP_LP_TARGET] && s.timer_control[`BIT_TC_MRT_STEP] && !link_in.osc_ok)
    begin
      mrt_tick = link_in.rc_tick;
      mrt_mask = 12'h000;
    end
    else
    begin
      mrt_tick = link_in.fc_tick;
      mrt_mask = s.timer_control[`BIT_TC_MRT_STEP] ? 12'h1FF : 12'h03F;
    end
    if (step_end(s.mrt, mrt_tick, mrt_mask) && s.mrt_elapsed != 8'hFF)
      next_s.mrt_elapsed = s.mrt_elapsed + 8'h01;
    next_s.mrt = advance(s.mrt, mrt_tick, mrt_mask, mrt_exp);
    next_s.nrt = advance(s.nrt, link_in.fc_tick,
                         s.timer_control[`BIT_TC_NRT_STEP] ? 12'hFFF : 12'h03F, nrt_exp);
    next_s.gpt = advance(s.gpt, link_in.fc_tick, 12'h03F, gpt_exp);
    next_s.wut = advance(s.wut, link_in.rc_tick, 12'h000, wut_exp);

    // no-response expiry handling
    if (nrt_exp)
    begin
      ev_set[`BIT_EV_NRT] = 1'b1;
      if (!uncond || !link_in.rx_busy)
        next_s.rx_block = 1'b1;
    end
    if (link_in.reply_start && !uncond && s.nrt.run)
      next_s.nrt.run = 1'b0;
    if (gpt_exp)
      ev_set[`BIT_EV_GPT] = 1'b1;
    if (wut_exp && !wake_mode)
      ev_set[`BIT_EV_WUT] = 1'b1;

    // ****************************************************************
    // automatic starts
    // ****************************************************************
    if (link_in.tx_end && !target)
    begin
      next_s.mrt = load({8'h00, s.mrt_count});
      next_s.mrt_elapsed = 8'h00;
      next_s.mrt_squelch = s.timer_control[`BIT_TC_SQ_DYN];
      next_s.nrt = load(s.nrt_count);
      next_s.rx_block = 1'b0;
      next_s.sq_delay = 12'(SQ_CYCLES);
      next_s.sq_active = 1'b0;
    end
    if (link_in.field_on && target)
    begin
      next_s.mrt = load({8'h00, s.mrt_count});
      next_s.mrt_elapsed = 8'h00;
      next_s.mrt_squelch = 1'b0;
      next_s.rx_block = 1'b0;
    end
    if ((link_in.rx_sof && s.timer_control[`BIT_TC_GPT_SOF]) ||
        (link_in.rx_eof && s.timer_control[`BIT_TC_GPT_EOF]))
      next_s.gpt = load(s.gpt_count);

    // dynamic squelch window
    if (s.sq_delay != 12'h000)
    begin
      next_s.sq_delay = s.sq_delay - 12'h001;
      if (s.sq_delay == 12'h001 && s.mrt_squelch)
        next_s.sq_active = 1'b1;
    end
    if (s.sq_active && (s.mrt_elapsed >= s.squelch_count || !s.mrt.run))
      next_s.sq_active = 1'b0;

    // ****************************************************************
    // direct commands
    // ****************************************************************
    if (wr_cmd)
      unique case (bus_in.wdata)
        CMD_START_MRT:
        begin
          next_s.mrt = load({8'h00, s.mrt_count});
          next_s.mrt_elapsed = 8'h00;
          next_s.mrt_squelch = (s.squelch_count != 8'h00);
          next_s.sq_active = (s.squelch_count != 8'h00);
        end
        CMD_START_NRT: next_s.nrt = load(s.nrt_count);
        CMD_STOP_NRT:  next_s.nrt.run = 1'b0;
        CMD_START_GPT: next_s.gpt = load(s.gpt_count);
        CMD_START_WUT:
          if (!wake_mode)
            next_s.wut = load(wake_ticks(s.wakeup_ctrl[2:0]));
        CMD_STOP_ALL, CMD_SET_DEFAULT:
        begin
          next_s.mrt.run = 1'b0;
          next_s.gpt.run = 1'b0;
          next_s.wut.run = 1'b0;
          next_s.sq_active = 1'b0;
          next_s.sq_delay = 12'h000;
          if (!uncond)
            next_s.nrt.run = 1'b0;
          if (bus_in.wdata == CMD_SET_DEFAULT)
          begin
            next_s.method[0].init = 1'b0;
            next_s.method[1].init = 1'b0;
          end
        end
        default: ;
      endcase

    // ****************************************************************
    // wake-up sequencing and measurement evaluation
    // ****************************************************************
    unique case (s.wk)
      WK_IDLE:
        if (wake_mode)
        begin
          next_s.wut = load(wake_ticks(s.wakeup_ctrl[2:0]));
          next_s.wk = WK_WAIT;
        end
      WK_WAIT:
        if (!wake_mode)
        begin
          next_s.wk = WK_IDLE;
          next_s.wut.run = 1'b0; // leftover interval must not raise the command flag
        end
        else if (wut_exp)
        begin
          if (s.wakeup_ctrl[`BIT_WU_AMP_EN] || s.wakeup_ctrl[`BIT_WU_PHASE_EN])
          begin
            next_s.wk_phase = !s.wakeup_ctrl[`BIT_WU_AMP_EN];
            next_s.meas_req = 1'b1;
            next_s.wk = WK_MEAS;
          end
          else
            next_s.wut = load(wake_ticks(s.wakeup_ctrl[2:0]));
        end
      WK_MEAS:
        if (!wake_mode)
          next_s.wk = WK_IDLE;
        else if (meas_done_in)
        begin
          m = s.wk_phase;
          next_s.method[m].last = meas_value_in;
          ref10 = s.method[m].init ? s.method[m].avg_ref : {meas_value_in, 2'b00};
          ref8 = s.method[m].cfg[`BIT_CFG_HOST_REF] ? s.method[m].host_ref : ref10[9:2];
          diff = (meas_value_in > ref8) ? meas_value_in - ref8 : ref8 - meas_value_in;
          hit = diff > {4'h0, s.method[m].cfg[7:4]};
          if (hit)
            ev_set[`BIT_EV_WAKEUP] = 1'b1;
          delta = $signed({2'b00, ref10}) - $signed({2'b00, meas_value_in, 2'b00});
          if (!s.method[m].init)
            next_s.method[m].avg_ref = ref10;
          else if (!hit || s.method[m].cfg[`BIT_CFG_INCLUDE])
            next_s.method[m].avg_ref = 10'(ref10 - 10'(delta >>> s.method[m].cfg[2:1]));
          next_s.method[m].init = 1'b1;
          if (!s.wk_phase && s.wakeup_ctrl[`BIT_WU_PHASE_EN])
          begin
            next_s.wk_phase = 1'b1;
            next_s.meas_req = 1'b1;
          end
          else
          begin
            next_s.wut = load(wake_ticks(s.wakeup_ctrl[2:0]));
            next_s.wk = WK_WAIT;
          end
        end
      default: next_s.wk = WK_IDLE;
    endcase

    // sticky events: read of status clears, a new event wins
    if (bus_in.rd && bus_in.addr == `OFS_EVENT_STATUS)
      next_s.events = ev_set;
    else
      next_s.events = s.events | ev_set;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s               <= '0;
      s.op_control    <= `RST_OP_CONTROL;
      s.mrt_count     <= `RST_COUNT8;
      s.squelch_count <= `RST_COUNT8;
      s.timer_control <= `RST_TIMER_CONTROL;
      s.wakeup_ctrl   <= `RST_WAKEUP_CTRL;
      s.wk            <= WK_IDLE;
    end
    else
      s <= next_s;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rdata_out      = s.rdata;
  assign meas_req_out   = s.meas_req;
  assign meas_phase_out = s.wk_phase;
  assign rx_on_out      = link_in.rx_request & !s.mrt.run & !s.rx_block;
  assign squelch_out    = s.sq_active;
  assign rc_osc_en_out  = s.wut.run | (s.wk != WK_IDLE);
  assign events_out     = s.events;
endmodule

// ---- design/wakeup_timers_regs.svh ----
`ifndef WAKEUP_TIMERS_REGS_SVH
`define WAKEUP_TIMERS_REGS_SVH
// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_OP_CONTROL     8'h02
`define OFS_MRT_COUNT      8'h10
`define OFS_SQUELCH_COUNT  8'h11
`define OFS_NRT_HIGH       8'h12
`define OFS_NRT_LOW        8'h13
`define OFS_TIMER_CONTROL  8'h14
`define OFS_GPT_HIGH       8'h15
`define OFS_GPT_LOW        8'h16
`define OFS_EVENT_STATUS   8'h1A
`define OFS_TIMER_STATUS   8'h1B
`define OFS_WAKEUP_CTRL    8'h32
`define OFS_AMP_CONFIG     8'h33
`define OFS_COMMAND        8'h3F
// ****************************************************************
// field positions
// ****************************************************************
`define BIT_OP_TARGET      0
`define BIT_OP_LP_TARGET   1
`define BIT_OP_WAKEUP      2
`define BIT_TC_MRT_STEP    0
`define BIT_TC_NRT_STEP    1
`define BIT_TC_NRT_UNCOND  2
`define BIT_TC_SQ_DYN      3
`define BIT_TC_GPT_SOF     4
`define BIT_TC_GPT_EOF     5
`define BIT_WU_AMP_EN      3
`define BIT_WU_PHASE_EN    4
`define BIT_CFG_INCLUDE    0
`define BIT_CFG_HOST_REF   3
`define BIT_EV_WAKEUP      0
`define BIT_EV_NRT         1
`define BIT_EV_GPT         2
`define BIT_EV_WUT         3
// ****************************************************************
// reset values
// ****************************************************************
`define RST_OP_CONTROL     8'h00
`define RST_WAKEUP_CTRL    8'h0B
`define RST_TIMER_CONTROL  8'h00
`define RST_COUNT8         8'h00
// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_PS      8000
`define SQUELCH_DELAY_PS   18880000
`define RC_TICKS_PER_MS    27
`endif

// ---- design/wakeup_timers_pkg.sv ----
package wakeup_timers_pkg;
  // ****************************************************************
  // command codes and states
  // ****************************************************************
  typedef enum logic [7:0] {
    CMD_SET_DEFAULT = 8'hC1,
    CMD_STOP_ALL    = 8'hC2,
    CMD_START_MRT   = 8'hE0,
    CMD_START_NRT   = 8'hE1,
    CMD_STOP_NRT    = 8'hE2,
    CMD_START_GPT   = 8'hE3,
    CMD_START_WUT   = 8'hE4
  } cmd_type;

  typedef enum logic [1:0] {
    WK_IDLE = 2'b00,
    WK_WAIT = 2'b01,
    WK_MEAS = 2'b10
  } wk_state_type;

  // one down-counting timer and prescaler (carrier ticks; RC ticks for the WUT, and for the MRT with MRT step set in low-power target before crystal stable)
  typedef struct packed {
    logic        run;
    logic [15:0] cnt;
    logic [11:0] pre;
  } timer_type;

  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_type;

  // link-side events from framing and analog front end
  typedef struct packed {
    logic fc_tick;
    logic rc_tick;
    logic tx_end;
    logic reply_start;
    logic rx_busy;
    logic rx_sof;
    logic rx_eof;
    logic field_on;
    logic osc_ok;
    logic rx_request;
  } link_ev_type;

  // wake-up measurement method group
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] host_ref;
    logic [9:0] avg_ref;
    logic [7:0] last;
    logic       init;
  } method_type;

  typedef struct packed {
    logic [7:0]   op_control;
    logic [7:0]   mrt_count;
    logic [7:0]   squelch_count;
    logic [15:0]  nrt_count;
    logic [7:0]   timer_control;
    logic [15:0]  gpt_count;
    logic [7:0]   wakeup_ctrl;
    logic [3:0]   events;
    logic [7:0]   rdata;
    timer_type    mrt;
    logic [7:0]   mrt_elapsed;
    logic         mrt_squelch;
    timer_type    nrt;
    timer_type    gpt;
    timer_type    wut;
    logic         rx_block;
    logic [11:0]  sq_delay;
    logic         sq_active;
    wk_state_type wk;
    logic         wk_phase;
    logic         meas_req;
    method_type [1:0] method;
  } state_type;
endpackage

// ---- verif/wakeup_timers_monitor.sv ----
`timescale 1ns/1ps
module wakeup_timers_monitor
  import wakeup_timers_pkg::*;
(
  input wire logic                           clk_in,        // clock
  input wire logic                           rst_b_in,      // reset
  input wire wakeup_timers_pkg::bus_req_type bus_in,        // bus request
  input wire logic [7:0]                     rdata_out,     // read data
  input wire wakeup_timers_pkg::link_ev_type link_in,       // link events
  input wire logic                           meas_done_in,  // result valid
  input wire logic                           meas_req_out,  // request pulse
  input wire logic                           rx_on_out,     // receiver on
  input wire logic                           rc_osc_en_out, // rc enable
  input wire logic [3:0]                     events_out     // event flags
);
  // ****
  // checks on the port timing
  // ****
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // event register read in the previous cycle
  sequence ev_read;
    $past(bus_in.rd) && $past(bus_in.addr) == 8'h1A;
  endsequence
  rdata_idle_a: assert property (!$past(bus_in.rd) |-> rdata_out == 8'h00)
    else $error("read data not idle");
  read_report_a: assert property (ev_read |-> rdata_out == {4'h0, $past(events_out)})
    else $error("event read wrong");
  event_hold_a: assert property ((|($past(events_out) & ~events_out)) |-> ev_read)
    else $error("event lost without read");
  rx_gate_a: assert property (!link_in.rx_request |-> !rx_on_out)
    else $error("receiver on without request");
  meas_pulse_a: assert property (meas_req_out |=> !meas_req_out)
    else $error("request not a pulse");
  meas_wake_a: assert property (meas_req_out |-> rc_osc_en_out)
    else $error("request outside wake mode");
  wut_flag_a: assert property ($rose(events_out[3]) |-> $past(rc_osc_en_out) || $past(rc_osc_en_out, 2))
    else $error("wake flag without timer");
  wake_event_a: assert property ($rose(events_out[0]) |-> $past(meas_done_in) || $past(meas_done_in, 2)
    || $past(meas_done_in, 3))
    else $error("wake event without result");
  reset_quiet_a: assert property ($rose(rst_b_in) |-> events_out == 4'h0 && !meas_req_out)
    else $error("outputs busy after reset");
endmodule
bind wakeup_timers wakeup_timers_monitor i_monitor (.clk_in(clk_in), .rst_b_in(rst_b_in), .bus_in(bus_in),
  .rdata_out(rdata_out), .link_in(link_in), .meas_done_in(meas_done_in), .meas_req_out(meas_req_out),
  .rx_on_out(rx_on_out), .rc_osc_en_out(rc_osc_en_out), .events_out(events_out));

// ---- verif/meas_partner.sv ----
`timescale 1ns/1ps
module meas_partner (
  input  wire logic       clk_in,    // clock
  input  wire logic       rst_b_in,  // reset
  input  wire logic       req_in,    // measurement request
  input  wire logic [7:0] level_in,  // value to report
  input  wire logic [7:0] delay_in,  // answer latency
  output logic [7:0]      value_out, // result
  output logic            done_out,  // result valid
  output logic [7:0]      count_out  // requests seen
);
  logic [7:0] wait_cnt;
  // answer after a latency; result toggles when not valid
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wait_cnt  <= 8'h00;
      count_out <= 8'h00;
      value_out <= 8'h00;
      done_out  <= 1'b0;
    end
    else
    begin
      done_out  <= (wait_cnt == 8'h01);
      value_out <= (wait_cnt == 8'h01) ? level_in : ~value_out;
      if (req_in)
      begin
        wait_cnt  <= delay_in;
        count_out <= count_out + 8'h01;
      end
      else if (wait_cnt != 8'h00)
        wait_cnt <= wait_cnt - 8'h01;
    end
  end
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module testbench;
  import wakeup_timers_pkg::*;
  logic        clk_in;
  logic        rst_b_in;
  bus_req_type bus;
  link_ev_type link;
  logic [4:0]  ev;
  logic        rxreq;
  logic [7:0]  rdata;
  logic [7:0]  mval;
  logic [7:0]  level;
  logic [7:0]  dly;
  logic [7:0]  mcnt;
  logic        mdone;
  logic        mreq;
  logic        rx_on;
  logic        rc_en;
  logic        sq_on;
  logic [3:0]  events;
  int          err_count;
  int          samples_checked;
  int          n;
  // carrier and rc ticks every cycle, crystal stable
  assign link = '{1'b1, 1'b1, ev[0], ev[1], 1'b0, ev[2], ev[3], ev[4], 1'b1, rxreq};
  wakeup_timers i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .bus_in(bus), .rdata_out(rdata), .link_in(link),
    .meas_value_in(mval), .meas_done_in(mdone), .meas_req_out(mreq), .meas_phase_out(), .rx_on_out(rx_on),
    .squelch_out(sq_on), .rc_osc_en_out(rc_en), .events_out(events));
  meas_partner i_partner (.clk_in(clk_in), .rst_b_in(rst_b_in), .req_in(mreq), .level_in(level),
    .delay_in(dly), .value_out(mval), .done_out(mdone), .count_out(mcnt));
  // ****
  // bus and event helpers
  // ****
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk_in);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk_in);
    bus.rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  task automatic pulse(input int k);
    @(posedge clk_in);
    ev[k] <= 1'b1;
    @(posedge clk_in);
    ev[k] <= 1'b0;
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk_in);
    #1;
  endtask
  task automatic wait_ev(input int b, input int lim);
    n = 0;
    while (events[b] !== 1'b1 && n < lim)
    begin
      @(posedge clk_in);
      #1 n++;
    end
    `CHK(events[b], 1'b1)
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_regs;
    rd(8'h32, 8'h0B);
    rd(8'h20, 8'h00);
    wr(8'h35, 8'h55);
    rd(8'h35, 8'h00);
    wr(8'h10, 8'hA5);
    rd(8'h10, 8'hA5);
  endtask
  task automatic t_nrt;
    wr(8'h10, 8'h02);
    wr(8'h12, 8'h00);
    wr(8'h13, 8'h04);
    rxreq <= 1'b1;
    pulse(0);
    idle(10);
    `CHK(rx_on, 1'b0)
    idle(140);
    `CHK(rx_on, 1'b1)
    wait_ev(1, 400);
    `CHK(n + 150 inside {[250:262]}, 1'b1)
    `CHK(rx_on, 1'b0)
    rd(8'h1A, 8'h02);
  endtask
  task automatic t_nrt_cmd;
    wr(8'h3F, CMD_START_NRT);
    idle(200);
    wr(8'h3F, CMD_START_NRT);
    idle(200);
    `CHK(events, 4'h0)
    pulse(1);
    idle(300);
    `CHK(events, 4'h0)
    wr(8'h3F, CMD_START_NRT);
    wr(8'h3F, CMD_STOP_NRT);
    idle(300);
    `CHK(events, 4'h0)
  endtask
  task automatic t_uncond;
    wr(8'h14, 8'h04);
    wr(8'h15, 8'h00);
    wr(8'h16, 8'h02);
    wr(8'h3F, CMD_START_GPT);
    wr(8'h3F, CMD_START_NRT);
    wr(8'h3F, CMD_STOP_ALL);
    wait_ev(1, 300);
    rd(8'h1A, 8'h02);
  endtask
  task automatic t_gpt;
    for (int k = 0; k < 3; k++)
    begin
      wr(8'h14, (k == 2) ? 8'h00 : 8'h10 << k);
      if (k == 2)
        wr(8'h3F, CMD_START_GPT);
      else
        pulse(k + 2);
      wait_ev(2, 200);
      rd(8'h1A, 8'h04);
    end
  endtask
  task automatic t_wut;
    wr(8'h32, 8'h00);
    wr(8'h3F, CMD_START_WUT);
    #1 `CHK(rc_en, 1'b1)
    wait_ev(3, 400);
    `CHK(n inside {[262:278]}, 1'b1)
    rd(8'h1A, 8'h08);
  endtask
  task automatic t_mask;
    wr(8'h11, 8'h03);
    wr(8'h14, 8'h01);
    wr(8'h02, 8'h01);
    pulse(4);
    idle(600);
    `CHK(rx_on, 1'b0)
    idle(500);
    `CHK(rx_on, 1'b1)
    `CHK(sq_on, 1'b0)
    wr(8'h3F, CMD_START_MRT);
    #1 `CHK(sq_on, 1'b1)
    idle(1100);
    `CHK(sq_on, 1'b0)
    wr(8'h10, 8'h40);
    wr(8'h11, 8'h30);
    wr(8'h14, 8'h08);
    wr(8'h02, 8'h00);
    pulse(0);
    idle(2300);
    `CHK(sq_on, 1'b0)
    idle(100);
    `CHK(sq_on, 1'b1)
    idle(800);
    `CHK(sq_on, 1'b0)
    rd(8'h1A, 8'h02);
    wr(8'h3F, CMD_STOP_ALL);
    rd(8'h1B, 8'h00);
  endtask
  task automatic t_wake;
    wr(8'h33, 8'h10);
    wr(8'h32, 8'h08);
    level <= 8'h40;
    wr(8'h02, 8'h06);
    idle(400);
    `CHK(mcnt, 8'h00)
    wr(8'h02, 8'h04);
    n = 0;
    while (mcnt !== 8'h01 && n < 400)
    begin
      @(posedge clk_in);
      #1 n++;
    end
    idle(10);
    rd(8'h36, 8'h40);
    rd(8'h35, 8'h40);
    level <= 8'hC0;
    dly   <= 8'h28;
    wait_ev(0, 500);
    rd(8'h35, 8'h40);
    wr(8'h02, 8'h00);
    wr(8'h33, 8'h13);
    rd(8'h1A, 8'h01);
    wr(8'h02, 8'h04);
    wait_ev(0, 500);
    rd(8'h35, 8'h80);
    wr(8'h02, 8'h00);
  endtask
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // clock
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    end_of_test;
  end
  // main sequence
  initial
  begin
    err_count       = 0;
    samples_checked = 0;
    rst_b_in        = 1'b0;
    bus             = '0;
    ev              = 5'h00;
    rxreq           = 1'b0;
    level           = 8'h00;
    dly             = 8'h03;
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_regs;
    t_nrt;
    t_nrt_cmd;
    t_uncond;
    t_gpt;
    t_wut;
    t_mask;
    t_wake;
    end_of_test;
  end
endmodule
